// [design/dcc_map.vh]
// register map, field positions and reset values of the dma channel control block
// assumes a 32-bit apb slave with one aligned word per register
// Behaviour
// - the channel works only while the module enable bit is one.
// - hardware start triggers begin a transfer only while the start trigger enable is one.
// - the transaction active flag shows a transfer underway; software writes it, hardware sets and clears it.
// - abort triggers stop the transfer only while the abort trigger enable is one.
// - the buffer occupied flag is one from a source read until the byte is written to the destination.
// - the destination step mode holds, increments or decrements the 16-bit destination pointer; 11 is reserved.
// - with destination reload stop set, a destination counter reload clears the start trigger enable.
// - the source region select picks data space (00), program flash (01) or data eeprom (1x).
// - the source step mode holds, increments or decrements the 22-bit source pointer; 11 is reserved.
// - with source reload stop set, a source counter reload clears the start trigger enable.
// - a read-only register shows the holding buffer byte.
// - the source start address is 22 bits over low, high and top registers, the top one six bits wide.
// - unimplemented main control bits ignore writes and read zero.
// - all registers return to defaults on reset and when software clears the module enable.
// - an accepted abort clears both trigger enables at once, lets the started access finish, then clears active.
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
`define DCC_OFS_MAIN      12'h000
`define DCC_OFS_ADDR      12'h004
`define DCC_OFS_BUF       12'h008
`define DCC_OFS_SSAL      12'h00C
`define DCC_OFS_SSAH      12'h010
`define DCC_OFS_SSAU      12'h014
`define DCC_OFS_DSAL      12'h018
`define DCC_OFS_DSAH      12'h01C
`define DCC_OFS_IRQST     12'h020
`define DCC_OFS_IRQMSK    12'h024
`define DCC_BIT_EN        7
`define DCC_BIT_SIRQ      6
`define DCC_BIT_ACT       5
`define DCC_BIT_AIRQ      2
`define DCC_BIT_OCC       0
`define DCC_MAIN_WMASK    8'hE4
`define DCC_SSAU_MASK     8'h3F
`define DCC_RST8          8'h00
`define DCC_MODE_HOLD     2'h0
`define DCC_MODE_INC      2'h1
`define DCC_MODE_DEC      2'h2
`define DCC_REG_DATA      2'h0
`define DCC_REG_PFM       2'h1
`define DCC_IRQ_DONE      0
`define DCC_IRQ_ABORT     1
`define DCC_IRQ_RELOAD    2
`endif

// [design/dcc_channel.v]
// dma channel control registers and a simple byte mover sequencer
// assumes the arbiter grants the bus access; source reads and destination writes finish on busDone
`timescale 1ns/1ps
`include "dcc_map.vh"
module dcc_channel #(
    parameter SRC_W = 22,
    parameter DST_W = 16
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output wire             pready,
    output wire             pslverr,
    // triggers and counters
    input  wire             startTrig,
    input  wire             abortTrig,
    input  wire             srcReload,
    input  wire             dstReload,
    input  wire             msgStart,
    // system bus access
    output reg              busReq,
    output reg              busWrite,
    output reg  [SRC_W-1:0] srcPtr,
    output reg  [DST_W-1:0] dstPtr,
    output reg  [1:0]       srcRegion,
    output reg  [7:0]       busWdata,
    input  wire [7:0]       busRdata,
    input  wire             busDone,
    // interrupt
    output wire             irq
);
    ////////////////////////////////////////////////////////////////////////
    localparam ST_IDLE = 2'h0;
    localparam ST_RD   = 2'h1;
    localparam ST_WR   = 2'h2;

    reg [7:0]       main_q;
    reg [7:0]       addr_q;
    reg [7:0]       buf_q;
    reg [21:0]      ssa_q;
    reg [15:0]      dsa_q;
    reg [2:0]       irqSt_q;
    reg [2:0]       irqMsk_q;
    reg [1:0]       state_q;
    reg             abortPend_q;

    wire            wrEn   = psel & penable & pwrite;
    wire            rdEn   = psel & penable & ~pwrite;
    wire            en     = main_q[`DCC_BIT_EN];
    wire            active = main_q[`DCC_BIT_ACT];
    wire [1:0]      destination_step_mode  = addr_q[7:6];
    wire            dStop  = addr_q[5];
    wire [1:0]      source_step_mode  = addr_q[2:1];
    wire            sStop  = addr_q[0];
    wire            mainWr = wrEn & (paddr == `DCC_OFS_MAIN);
    wire            startOk = en & main_q[`DCC_BIT_SIRQ] & startTrig;
    wire            abortOk = en & main_q[`DCC_BIT_AIRQ] & abortTrig & active;
    wire            reload  = en & (srcReload | dstReload);
    wire            xferEnd = (state_q == ST_WR) & busDone;
    wire            stopNow = abortOk | abortPend_q;
    // software clearing the enable resets the whole channel
    wire            swKill  = mainWr & ~pwdata[`DCC_BIT_EN];

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(irqSt_q & irqMsk_q);

    ////////////////////////////////////////////////////////////////////////
    // read mux, reserved bits read zero
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `DCC_OFS_MAIN:   prdata[7:0] = main_q & `DCC_MAIN_WMASK | {7'h00, main_q[`DCC_BIT_OCC]};
            `DCC_OFS_ADDR:   prdata[7:0] = addr_q;
            `DCC_OFS_BUF:    prdata[7:0] = buf_q;
            `DCC_OFS_SSAL:   prdata[7:0] = ssa_q[7:0];
            `DCC_OFS_SSAH:   prdata[7:0] = ssa_q[15:8];
            `DCC_OFS_SSAU:   prdata[7:0] = {2'h0, ssa_q[21:16]};
            `DCC_OFS_DSAL:   prdata[7:0] = dsa_q[7:0];
            `DCC_OFS_DSAH:   prdata[7:0] = dsa_q[15:8];
            `DCC_OFS_IRQST:  prdata[2:0] = irqSt_q;
            `DCC_OFS_IRQMSK: prdata[2:0] = irqMsk_q;
            default:         prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // step a pointer by mode; the reserved code holds like 00
    function [21:0] stepPtr;
        input [21:0] p;
        input [1:0]  m;
        begin
            case (m)
                `DCC_MODE_INC: stepPtr = p + 22'h000001;
                `DCC_MODE_DEC: stepPtr = p - 22'h000001;
                default:       stepPtr = p;
            endcase
        end
    endfunction

    wire [21:0] srcNext = stepPtr(srcPtr, source_step_mode);
    wire [21:0] dstNext = stepPtr({6'h00, dstPtr}, destination_step_mode);

    ////////////////////////////////////////////////////////////////////////
    // write strobes per register
    wire            wrAddr   = wrEn & (paddr == `DCC_OFS_ADDR);
    wire            wrSsaL   = wrEn & (paddr == `DCC_OFS_SSAL);
    wire            wrSsaH   = wrEn & (paddr == `DCC_OFS_SSAH);
    wire            wrSsaU   = wrEn & (paddr == `DCC_OFS_SSAU);
    wire            wrDsaL   = wrEn & (paddr == `DCC_OFS_DSAL);
    wire            wrDsaH   = wrEn & (paddr == `DCC_OFS_DSAH);
    wire            wrMsk    = wrEn & (paddr == `DCC_OFS_IRQMSK);
    // sequencer events
    wire            idleNow  = (state_q == ST_IDLE);
    wire            idleGo   = idleNow & en & active & ~stopNow;
    wire            idleStop = idleNow & stopNow & active;
    wire            rdEnd    = (state_q == ST_RD) & busDone;
    wire            rdStop   = rdEnd & stopNow;
    wire            ptrLoad  = en & (msgStart | reload);
    wire            stopHit  = en & ((srcReload & sStop) | (dstReload & dStop));
    reg  [7:0]      main_d;

    ////////////////////////////////////////////////////////////////////////
    // main control next value; hardware set and clear win over a software write
    always @* begin
        main_d = main_q;
        if (mainWr)
            main_d = (pwdata[7:0] & `DCC_MAIN_WMASK) | {7'h00, main_q[`DCC_BIT_OCC]};
        if (startOk)
            main_d[`DCC_BIT_ACT] = 1'b1;
        if (stopHit)
            main_d[`DCC_BIT_SIRQ] = 1'b0;
        if (abortOk) begin
            main_d[`DCC_BIT_SIRQ] = 1'b0;
            main_d[`DCC_BIT_AIRQ] = 1'b0;
        end
        if (idleStop | rdStop)
            main_d[`DCC_BIT_ACT] = 1'b0;
        if (rdEnd)
            main_d[`DCC_BIT_OCC] = 1'b1;
        if (xferEnd) begin
            main_d[`DCC_BIT_OCC] = 1'b0;
            if (stopNow | srcReload | dstReload)
                main_d[`DCC_BIT_ACT] = 1'b0;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            main_q <= `DCC_RST8;
        else if (swKill)
            main_q <= `DCC_RST8;
        else
            main_q <= main_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // software-only registers
    always @(posedge mclk or posedge rst) begin
        if (rst)
            addr_q <= `DCC_RST8;
        else if (swKill)
            addr_q <= `DCC_RST8;
        else if (wrAddr)
            addr_q <= pwdata[7:0];
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            ssa_q <= 22'h000000;
        else if (swKill)
            ssa_q <= 22'h000000;
        else begin
            if (wrSsaL)
                ssa_q[7:0] <= pwdata[7:0];
            if (wrSsaH)
                ssa_q[15:8] <= pwdata[7:0];
            if (wrSsaU)
                ssa_q[21:16] <= pwdata[5:0];
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            dsa_q <= 16'h0000;
        else if (swKill)
            dsa_q <= 16'h0000;
        else begin
            if (wrDsaL)
                dsa_q[7:0] <= pwdata[7:0];
            if (wrDsaH)
                dsa_q[15:8] <= pwdata[7:0];
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            irqMsk_q <= 3'h0;
        else if (swKill)
            irqMsk_q <= 3'h0;
        else if (wrMsk)
            irqMsk_q <= pwdata[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // holding buffer, its copy towards the destination and the region follower
    always @(posedge mclk or posedge rst) begin
        if (rst)
            buf_q <= `DCC_RST8;
        else if (swKill)
            buf_q <= `DCC_RST8;
        else if (rdEnd)
            buf_q <= busRdata;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            busWdata <= 8'h00;
        else if (swKill)
            busWdata <= 8'h00;
        else if (rdEnd)
            busWdata <= busRdata;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            srcRegion <= 2'h0;
        else if (swKill)
            srcRegion <= 2'h0;
        else
            srcRegion <= addr_q[4:3];
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers; a step in the same cycle as a load wins
    // the reserved step code holds, so a bad setting cannot run the pointer away
    always @(posedge mclk or posedge rst) begin
        if (rst)
            srcPtr <= {SRC_W{1'b0}};
        else if (swKill)
            srcPtr <= {SRC_W{1'b0}};
        else begin
            if (ptrLoad)
                srcPtr <= ssa_q[SRC_W-1:0];
            if (rdEnd)
                srcPtr <= srcNext[SRC_W-1:0];
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            dstPtr <= {DST_W{1'b0}};
        else if (swKill)
            dstPtr <= {DST_W{1'b0}};
        else begin
            if (ptrLoad)
                dstPtr <= dsa_q;
            if (xferEnd)
                dstPtr <= dstNext[DST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // an abort seen mid-access waits here until that access ends
    always @(posedge mclk or posedge rst) begin
        if (rst)
            abortPend_q <= 1'b0;
        else if (swKill)
            abortPend_q <= 1'b0;
        else if (idleNow | rdStop | xferEnd)
            abortPend_q <= 1'b0;
        else if (abortOk)
            abortPend_q <= 1'b1;
    end

    // sequencer: one source read, then one destination write per byte
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q  <= ST_IDLE;
            busReq   <= 1'b0;
            busWrite <= 1'b0;
        end else if (swKill) begin
            state_q  <= ST_IDLE;
            busReq   <= 1'b0;
            busWrite <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (idleGo) begin
                        busReq   <= 1'b1;
                        busWrite <= 1'b0;
                        state_q  <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (rdStop) begin
                        // finish the started read, then stop
                        busReq  <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (rdEnd) begin
                        busWrite <= 1'b1;
                        state_q  <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (xferEnd) begin
                        busReq   <= 1'b0;
                        busWrite <= 1'b0;
                        state_q  <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events: set wins over the clear-on-read
    wire       evDone   = xferEnd & ~swKill;
    wire       evAbort  = abortOk;
    wire       evReload = reload;
    wire [2:0] irqSet   = {evReload, evAbort, evDone};
    wire       stRd     = rdEn & (paddr == `DCC_OFS_IRQST);
    reg  [2:0] irqSt_d;
    always @* begin
        irqSt_d = irqSt_q;
        if (stRd)
            irqSt_d = 3'h0;
        irqSt_d = irqSt_d | irqSet;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst)
            irqSt_q <= 3'h0;
        else if (swKill)
            irqSt_q <= 3'h0;
        else
            irqSt_q <= irqSt_d;
    end
endmodule // dcc_channel

// [verif/dcc_props.sv]
// port checker for the dma channel control block
// assumes one clock mclk and async active-high rst
`timescale 1ns/1ps
module dcc_props #(parameter SRC_W = 22, parameter DST_W = 16) (
    // apb, triggers and bus side
    input wire             mclk, rst, psel, penable, pwrite, irq,
    input wire [11:0]      paddr,
    input wire [31:0]      pwdata, prdata,
    input wire             msgStart, srcReload, dstReload, busReq, busWrite, busDone,
    input wire [SRC_W-1:0] srcPtr,
    input wire [DST_W-1:0] dstPtr,
    input wire [1:0]       srcRegion,
    input wire [7:0]       busWdata, busRdata
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);
    reg  [1:0] smrQ;
    wire       acc    = psel && penable;
    wire       offWr  = acc && pwrite && paddr == 12'h000 && !pwdata[7];
    wire       rdDone = busReq && !busWrite && busDone;
    wire       wrDone = busReq && busWrite && busDone;
    wire       noLoad = !msgStart && !srcReload && !dstReload && !offWr;
    // last region field written, so the follower can be judged later
    always @(posedge mclk) if (acc && pwrite && paddr == 12'h004) smrQ <= pwdata[4:3];
    a_main_gaps: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 0 && prdata[4:3] == 0 && !prdata[1])
        else $error("main control gap bits set");
    a_top_six: assert property (acc && !pwrite && paddr == 12'h014 |-> prdata[31:6] == 0)
        else $error("start top has extra bits");
    a_region_follows: assert property (acc && pwrite && paddr == 12'h004 |-> ##2 srcRegion == smrQ)
        else $error("region output off");
    a_buf_latch: assert property (rdDone && !offWr |=> busWdata == $past(busRdata))
        else $error("holding byte not latched");
    a_src_step: assert property (rdDone && noLoad |=>
        srcPtr == $past(srcPtr) || srcPtr == $past(srcPtr) + 1'b1 || srcPtr == $past(srcPtr) - 1'b1)
        else $error("source step wrong");
    a_dst_step: assert property (wrDone && noLoad |=>
        dstPtr == $past(dstPtr) || dstPtr == $past(dstPtr) + 1'b1 || dstPtr == $past(dstPtr) - 1'b1)
        else $error("destination step wrong");
    a_src_still: assert property (!rdDone && noLoad |=> $stable(srcPtr))
        else $error("source moved without read");
    a_off_idle: assert property (offWr |=> !busReq && !irq && srcPtr == 0 && dstPtr == 0)
        else $error("channel busy after disable");
    c_wr: cover property (wrDone);
    c_irq: cover property (irq);
    c_byte: cover property (rdDone ##[1:20] wrDone);
endmodule // dcc_props
bind dcc_channel dcc_props #(.SRC_W(SRC_W), .DST_W(DST_W)) props_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .irq(irq),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .msgStart(msgStart), .srcReload(srcReload),
    .dstReload(dstReload), .busReq(busReq), .busWrite(busWrite), .busDone(busDone), .srcPtr(srcPtr),
    .dstPtr(dstPtr), .srcRegion(srcRegion), .busWdata(busWdata), .busRdata(busRdata)
);

// [verif/dcc_bus_mem.sv]
// system bus memory model on the channel's far side
// assumes one access at a time, held until busDone
`timescale 1ns/1ps
module dcc_bus_mem (
    input wire        mclk, rst, busReq, busWrite,
    input wire [21:0] srcPtr,
    input wire [7:0]  lat,
    output reg [7:0]  busRdata,
    output reg        busDone
);
    reg [7:0] cnt;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            busDone <= 1'b0;
            cnt <= 8'h00;
            busRdata <= 8'h00;
        end else if (busDone || !busReq) begin
            // idle cycle after each answer; data toggles so stale bytes never look valid
            busDone <= 1'b0;
            cnt <= 8'h00;
            busRdata <= ~busRdata;
        end else if (cnt == lat) begin
            busDone <= 1'b1;
            busRdata <= srcPtr[7:0] ^ 8'h5A;
        end else begin
            cnt <= cnt + 8'h01;
            busRdata <= ~busRdata;
        end
    end
endmodule // dcc_bus_mem

// [verif/dcc_channel_bench.sv]
// self-checking bench for the dma channel control block
// assumes zero-wait apb slave and a byte memory on the far side
`timescale 1ns/1ps
module dcc_channel_bench;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        startTrig = 0, abortTrig = 0, srcReload = 0, dstReload = 0, msgStart = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [7:0]  lat = 8'h08;
    wire  [31:0] prdata;
    wire         pready, pslverr, busReq, busWrite, busDone, irq;
    wire  [21:0] srcPtr;
    wire  [15:0] dstPtr;
    wire  [1:0]  srcRegion;
    wire  [7:0]  busWdata, busRdata;
    int          errors = 0, samplesChecked = 0;
    dcc_channel dut_u (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .startTrig(startTrig),
        .abortTrig(abortTrig), .srcReload(srcReload), .dstReload(dstReload), .msgStart(msgStart),
        .busReq(busReq), .busWrite(busWrite), .srcPtr(srcPtr), .dstPtr(dstPtr), .srcRegion(srcRegion),
        .busWdata(busWdata), .busRdata(busRdata), .busDone(busDone), .irq(irq)
    );
    dcc_bus_mem mem_u (
        .mclk(mclk), .rst(rst), .busReq(busReq), .busWrite(busWrite), .srcPtr(srcPtr), .lat(lat),
        .busRdata(busRdata), .busDone(busDone)
    );
    initial forever #25 mclk = ~mclk;
    task automatic results();
        $display("checks %0d errors %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk) penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin errors++; results(); end
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic waitBus(input logic wr, input logic done, input logic req);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge mclk);
            if (busReq === req && (!req || busWrite === wr && busDone === done)) break;
        end
        if (n == 300) begin errors++; results(); end
    endtask
    task automatic regs_check();
        int r;
        bus(0, 12'h000, 0); chk(rd, 0);
        bus(0, 12'h008, 0); chk(rd, 0);
        bus(1, 12'h000, 32'hDF); bus(0, 12'h000, 0); chk(rd, 32'hC4);
        chk(pslverr, 0);
        bus(1, 12'h014, 32'hFF); bus(0, 12'h014, 0); chk(rd, 32'h3F);
        bus(1, 12'h00C, 32'hA5); bus(0, 12'h00C, 0); chk(rd, 32'hA5);
        for (r = 0; r < 4; r++) begin
            bus(1, 12'h004, r << 3);
            repeat (2) @(posedge mclk);
            chk(srcRegion, r);
        end
        bus(1, 12'h000, 0); bus(0, 12'h004, 0); chk(rd, 0);
        bus(0, 12'h014, 0); chk(rd, 0);
    endtask
    task automatic run(input logic [7:0] mode, input logic [21:0] s1, input logic [15:0] d1);
        bus(1, 12'h00C, 32'h10); bus(1, 12'h018, 32'h34); bus(1, 12'h01C, 32'h12);
        bus(1, 12'h004, mode); bus(1, 12'h024, 32'h7); bus(1, 12'h000, 32'hC4);
        msgStart <= 1;
        @(posedge mclk) msgStart <= 0;
        @(posedge mclk);
        chk(srcPtr, 22'h10); chk(dstPtr, 16'h1234);
        startTrig <= 1;
        @(posedge mclk) startTrig <= 0;
        waitBus(1, 1, 1); chk(busWdata, 8'h4A); chk(srcPtr, s1);
        @(posedge mclk);
        chk(dstPtr, d1);
        bus(0, 12'h008, 0); chk(rd, 32'h4A);
        abortTrig <= 1;
        @(posedge mclk) abortTrig <= 0;
        waitBus(0, 0, 0);
        bus(0, 12'h000, 0); chk(rd & 32'hE4, 32'h80); chk(irq, 1);
        chk(rd & 32'h01, {31'h0, lat != 0});
        bus(0, 12'h020, 0); chk(rd & 2, 2);
        @(posedge mclk);
        chk(irq, 0);
        startTrig <= 1;
        @(posedge mclk) startTrig <= 0;
        repeat (10) @(posedge mclk);
        chk(busReq, 0);
    endtask
    task automatic reload_stop();
        int i;
        for (i = 0; i < 2; i++) begin
            bus(1, 12'h024, 0); bus(1, 12'h004, i ? 32'h01 : 32'h20); bus(1, 12'h000, 32'hC0);
            srcReload <= i[0];
            dstReload <= !i[0];
            @(posedge mclk);
            srcReload <= 0;
            dstReload <= 0;
            bus(0, 12'h000, 0); chk(rd, 32'h80); chk(irq, 0);
            bus(1, 12'h024, 32'h4);
            @(posedge mclk);
            chk(irq, 1);
            bus(0, 12'h020, 0);
            @(posedge mclk);
            chk(irq, 0);
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        regs_check();
        run(8'h82, 22'h11, 16'h1233);
        run(8'h44, 22'h0F, 16'h1235);
        lat <= 8'h00;
        run(8'h00, 22'h10, 16'h1234);
        reload_stop();
        bus(1, 12'h000, 32'hA0); waitBus(0, 0, 1); chk(busReq, 1);
        bus(1, 12'h000, 0);
        @(posedge mclk);
        chk(busReq, 0);
        results();
    end
endmodule // dcc_channel_bench
